//--- common/las_pkg.sv
package las_pkg;

  // completion codes
  localparam logic [7:0] CC_NONE    = 8'h00;
  localparam logic [7:0] CC_UNRECOV = 8'h0C;
  localparam logic [7:0] CC_EXCEPT  = 8'h02;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // register byte offsets
  localparam logic [7:0] OFS_COMPL     = 8'h00;
  localparam logic [7:0] OFS_SUMMARY   = 8'h04;
  localparam logic [7:0] OFS_EXT       = 8'h08;
  localparam logic [7:0] OFS_PTR_HI    = 8'h0C;
  localparam logic [7:0] OFS_PTR_LO    = 8'h10;
  localparam logic [7:0] OFS_CTRL      = 8'h14;
  localparam logic [7:0] OFS_SENSE     = 8'h20;
  localparam logic [7:0] OFS_SENSE_END = 8'h40;

  // control write bits and control read bits
  localparam int CTRL_ACK_BIT   = 0;
  localparam int CTRL_RST_BIT   = 1;
  localparam int STAT_DONE_BIT  = 0;
  localparam int STAT_HALT_BIT  = 1;
  localparam int STAT_SENSE_BIT = 2;
  localparam int STAT_READY_BIT = 3;

  localparam int SENSE_DEPTH = 8;
  localparam int SENSE_IDX_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_WAIT, ST_SENSE, ST_HALT
  } las_state_t;

  // reserved bits of each extended category read as zero
  function automatic logic [7:0] ext_mask(input logic [2:0] cat);
    logic [7:0] m;
    m = 8'h00;
    case (cat)
      3'h1: m = 8'hCE;
      3'h2: m = 8'h9E;
      3'h3: m = 8'hFE;
      3'h4: m = 8'hFE;
      3'h5: m = 8'hD2;
      3'h6: m = 8'h76;
      3'h7: m = 8'h0E;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] cat_onehot(input logic [2:0] cat);
    return 8'h01 << cat;
  endfunction

  // flags in order {invalid hw, write fail, machine check, dsr}
  function automatic logic [7:0] unrecov_summary(input logic [3:0] f);
    return {f[3], f[2], f[1], 2'b00, f[0], 2'b00};
  endfunction

  function automatic logic ptr_needed(input logic [7:0] sum);
    return |sum[6:3];
  endfunction

endpackage

//--- common/las_reg_if.sv
// register access carried from the bus port to the register file
interface las_reg_if;
  logic [7:0]  adr;
  logic        we;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic        wrEn;
  logic [31:0] rdData;

  modport port (output adr, we, sel, wdat, wrEn, input rdData);
  modport regs (input adr, we, sel, wdat, wrEn, output rdData);
endinterface

//--- src/las_sense_mem.sv
// holds the automatic sense bytes; read data come from a register
module las_sense_mem #(
  parameter int DEPTH = las_pkg::SENSE_DEPTH,
  parameter int IDX_W = las_pkg::SENSE_IDX_W
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic             wrEn,
  input  wire logic [IDX_W-1:0] wrIdx,
  input  wire logic [7:0]       wrData,
  input  wire logic [IDX_W-1:0] rdIdx,
  output logic      [7:0]       rdData
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] cells;
    logic [7:0]            rd;
  } las_mem_st_t;

  las_mem_st_t st_q;
  las_mem_st_t st_d;

  //////////////////////////////////////////////////////////////////////
  // write port and registered read port
  always_comb begin
    st_d = st_q;
    if (wrEn) begin
      st_d.cells[wrIdx] = wrData;
    end
    st_d.rd = st_q.cells[rdIdx]; // old data on a same-cycle collision
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rd;

endmodule // las_sense_mem

//--- src/las_wb_port.sv
// classic wishbone slave: ack two edges after the request is seen
module las_wb_port (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  las_reg_if.port          bus
);

  typedef struct packed {
    logic        pend;
    logic        ack;
    logic [31:0] dat;
  } las_wb_st_t;

  las_wb_st_t st_q;
  las_wb_st_t st_d;

  //////////////////////////////////////////////////////////////////////
  // one wait cycle lets the sense memory register its read data
  always_comb begin
    st_d = st_q;
    st_d.pend = wb_cyc_i && wb_stb_i && !st_q.pend && !st_q.ack;
    st_d.ack = st_q.pend;
    st_d.dat = st_q.pend ? bus.rdData : 32'h0000_0000;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // request fields pass straight through; master holds them stable
  assign bus.adr  = wb_adr_i;
  assign bus.we   = wb_we_i;
  assign bus.sel  = wb_sel_i;
  assign bus.wdat = wb_dat_i;
  assign bus.wrEn = st_q.pend && wb_we_i;
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.dat;

endmodule // las_wb_port

//--- src/las_top.sv
// completion status reporting: unrecoverable error and exception classes
//
// Chosen here: the address map and the Wishbone register port.
module las_top #(
  parameter int DEPTH = las_pkg::SENSE_DEPTH,
  parameter int IDX_W = las_pkg::SENSE_IDX_W,
  parameter int PTR_W = 16
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // wishbone register port
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // reports from the adapter core, and sense index and status back to it
  input  wire logic             unrecovReq,
  input  wire logic [3:0]       unrecovFlags,
  input  wire logic             exceptReq,
  input  wire logic [2:0]       exceptCat,
  input  wire logic [7:0]       exceptDetail,
  input  wire logic             returnReq,
  input  wire logic [PTR_W-1:0] scbPtr,
  input  wire logic [7:0]       senseByte,
  output logic      [IDX_W-1:0] senseSel,
  output logic                  rptReady,
  output logic                  complDone,
  output logic                  adapterHalted,
  output logic                  adapterStop
);

  localparam int HALF_W = PTR_W / 2;

  typedef struct packed {
    las_pkg::las_state_t state;
    logic [7:0]          compl;
    logic [7:0]          summary;
    logic [7:0]          ext;
    logic [HALF_W-1:0]   ptrHi;
    logic [HALF_W-1:0]   ptrLo;
    logic                done;
    logic                halted;
    logic                senseValid;
    logic                ready;
    logic                stop;
    logic [IDX_W-1:0]    senseSel;
  } las_top_st_t;

  localparam las_top_st_t ST_RESET = '{
    state:      las_pkg::ST_IDLE,
    compl:      las_pkg::CC_NONE,
    summary:    las_pkg::RST_BYTE,
    ext:        las_pkg::RST_BYTE,
    ptrHi:      '0,
    ptrLo:      '0,
    done:       1'b0,
    halted:     1'b0,
    senseValid: 1'b0,
    ready:      1'b1,
    stop:       1'b0,
    senseSel:   '0
  };

  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(DEPTH - 1);

  las_top_st_t st_q;
  las_top_st_t st_d;

  las_reg_if   regBus ();

  logic [7:0]       memRd;
  logic             memWr;
  logic [IDX_W-1:0] memRdIdx;
  logic             ackWr;
  logic             rstWr;
  logic             senseHit;
  logic [7:0]       catMask;
  logic [7:0]       irlBit;

  //////////////////////////////////////////////////////////////////////
  // bus slave and sense buffer
  las_wb_port u_port (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .bus      (regBus.port)
  );

  // sense capture happens only while the core is otherwise frozen
  las_sense_mem #(
    .DEPTH (DEPTH),
    .IDX_W (IDX_W)
  ) u_sense (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wrEn     (memWr),
    .wrIdx    (st_q.senseSel),
    .wrData   (senseByte),
    .rdIdx    (memRdIdx),
    .rdData   (memRd)
  );

  //////////////////////////////////////////////////////////////////////
  // decode of the control register and the sense window
  always_comb begin
    memRdIdx = regBus.adr[IDX_W+1:2];
    senseHit = (regBus.adr >= las_pkg::OFS_SENSE) &&
               (regBus.adr < las_pkg::OFS_SENSE_END);
    ackWr = 1'b0;
    rstWr = 1'b0;
    if (regBus.wrEn && regBus.sel[0] &&
        regBus.adr == las_pkg::OFS_CTRL) begin
      ackWr = regBus.wdat[las_pkg::CTRL_ACK_BIT];
      rstWr = regBus.wdat[las_pkg::CTRL_RST_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read as zero
  always_comb begin
    regBus.rdData = 32'h0000_0000;
    if (regBus.adr == las_pkg::OFS_COMPL) begin
      regBus.rdData[7:0] = st_q.compl;
    end else if (regBus.adr == las_pkg::OFS_SUMMARY) begin
      regBus.rdData[7:0] = st_q.summary;
    end else if (regBus.adr == las_pkg::OFS_EXT) begin
      regBus.rdData[7:0] = st_q.ext;
    end else if (regBus.adr == las_pkg::OFS_PTR_HI) begin
      regBus.rdData[HALF_W-1:0] = st_q.ptrHi;
    end else if (regBus.adr == las_pkg::OFS_PTR_LO) begin
      regBus.rdData[HALF_W-1:0] = st_q.ptrLo;
    end else if (regBus.adr == las_pkg::OFS_CTRL) begin
      regBus.rdData[las_pkg::STAT_DONE_BIT]  = st_q.done;
      regBus.rdData[las_pkg::STAT_HALT_BIT]  = st_q.halted;
      regBus.rdData[las_pkg::STAT_SENSE_BIT] = st_q.senseValid;
      regBus.rdData[las_pkg::STAT_READY_BIT] = st_q.ready;
    end else if (senseHit) begin
      regBus.rdData[7:0] = memRd;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // exception field shaping
  always_comb begin
    catMask = las_pkg::ext_mask(exceptCat);
    irlBit  = {7'h00, returnReq};
  end

  //////////////////////////////////////////////////////////////////////
  // completion sequencer
  always_comb begin
    st_d = st_q;
    st_d.stop = 1'b0;
    memWr = 1'b0;
    // host acknowledge clears completion; a set below still wins
    if (ackWr) begin
      st_d.done = 1'b0;
    end
    case (st_q.state)
      las_pkg::ST_IDLE: begin
        // unrecoverable wins when both reports arrive together
        if (unrecovReq) begin
          st_d.compl = las_pkg::CC_UNRECOV;
          st_d.summary = las_pkg::unrecov_summary(unrecovFlags);
          st_d.ext = las_pkg::RST_BYTE;
          st_d.senseSel = '0;
          st_d.senseValid = 1'b0;
          st_d.state = las_pkg::ST_SENSE;
        end else if (exceptReq && exceptCat != 3'h0) begin
          st_d.compl = las_pkg::CC_EXCEPT;
          st_d.summary = las_pkg::cat_onehot(exceptCat) | irlBit;
          st_d.ext = (exceptDetail & catMask) | irlBit;
          if (las_pkg::ptr_needed(las_pkg::cat_onehot(exceptCat))) begin
            st_d.ptrHi = scbPtr[PTR_W-1:HALF_W];
            st_d.ptrLo = scbPtr[HALF_W-1:0];
          end
          st_d.state = las_pkg::ST_LOAD;
        end
      end
      las_pkg::ST_LOAD: begin
        // status has stood a full cycle before done rises
        st_d.done = 1'b1;
        st_d.state = las_pkg::ST_WAIT;
      end
      las_pkg::ST_WAIT: begin
        if (!st_q.done) begin
          st_d.state = las_pkg::ST_IDLE;
        end
      end
      las_pkg::ST_SENSE: begin
        // one sense byte per cycle, core answers senseSel directly
        memWr = 1'b1;
        st_d.senseSel = st_q.senseSel + 1'b1;
        if (st_q.senseSel == LAST_IDX) begin
          st_d.senseSel = '0;
          st_d.senseValid = 1'b1;
          st_d.done = 1'b1;
          st_d.halted = 1'b1;
          st_d.state = las_pkg::ST_HALT;
        end
      end
      las_pkg::ST_HALT: begin
        // nothing more is taken until the adapter reset command
        st_d.state = las_pkg::ST_HALT;
      end
      default: begin
        st_d.state = las_pkg::ST_IDLE;
      end
    endcase
    // adapter reset stops everything but keeps sense data for logging
    if (rstWr) begin
      st_d = ST_RESET;
      st_d.senseValid = st_q.senseValid;
      st_d.stop = 1'b1;
    end
    st_d.ready = (st_d.state == las_pkg::ST_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign senseSel      = st_q.senseSel;
  assign rptReady      = st_q.ready;
  assign complDone     = st_q.done;
  assign adapterHalted = st_q.halted;
  assign adapterStop   = st_q.stop;

endmodule // las_top

//--- dv/las_core_model.sv
// adapter core stand-in: answers each sense index in the same cycle
module las_core_model (
  input  wire logic [2:0] senseSel,
  output logic      [7:0] senseByte
);
  timeunit 1ns;
  timeprecision 1ns;
  // index-dependent pattern so a stuck or skipped index shows up
  assign senseByte = 8'h5A ^ {5'h00, senseSel};
endmodule // las_core_model

//--- dv/las_top_asserts.sv
// watches the status port and the register bus of las_top
module las_top_asserts #(
  parameter int IDX_W = 3
) (
  input wire logic             core_clk,
  input wire logic             sys_rst,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  input wire logic             unrecovReq,
  input wire logic             exceptReq,
  input wire logic [2:0]       exceptCat,
  input wire logic [IDX_W-1:0] senseSel,
  input wire logic             rptReady,
  input wire logic             complDone,
  input wire logic             adapterHalted,
  input wire logic             adapterStop
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////
  // bus answers: fixed latency, single pulse, quiet data between
  AST_ACK_LATENCY: assert property ($rose(wb_stb_i) |->
    !wb_ack_o ##1 !wb_ack_o ##1 wb_ack_o) else $error("ack latency");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  // report handling
  AST_EXC_DONE: assert property (rptReady && exceptReq && !unrecovReq &&
    exceptCat != 3'h0 |=> !rptReady ##1 complDone) else $error("exception");
  AST_UNREC_DONE: assert property (rptReady && unrecovReq |=>
    !complDone [*8] ##1 (complDone && adapterHalted)) else $error("unrecov");
  AST_SENSE_STEP: assert property (rptReady && unrecovReq |=>
    senseSel == IDX_W'(0) ##1 senseSel == IDX_W'(1)) else $error("sense");
  AST_DONE_HOLD: assert property ($fell(complDone) |->
    $past(wb_cyc_i && wb_we_i)) else $error("done dropped by itself");
  AST_HALT_HOLD: assert property ($fell(adapterHalted) |->
    $past(wb_cyc_i && wb_we_i)) else $error("halt dropped by itself");
  AST_STOP_PULSE: assert property (adapterStop |->
    $past(wb_cyc_i && wb_we_i) ##1 !adapterStop) else $error("stop pulse");
  AST_BUSY_DONE: assert property (complDone |-> !rptReady)
    else $error("ready while completion pending");
endmodule // las_top_asserts

bind las_top las_top_asserts #(.IDX_W(IDX_W)) uChk (
  .core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .unrecovReq(unrecovReq), .exceptReq(exceptReq),
  .exceptCat(exceptCat), .senseSel(senseSel), .rptReady(rptReady),
  .complDone(complDone), .adapterHalted(adapterHalted),
  .adapterStop(adapterStop));

//--- dv/link_adapter_error_status_bench.sv
// self-checking bench for the completion status block
module link_adapter_error_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, ack, unrecovReq = 1'b0, exceptReq = 1'b0;
  logic        returnReq = 1'b0, rptReady, complDone, halted, stop;
  logic        stopSeen = 1'b0;
  logic [7:0]  adr = 8'h00, exceptDetail = 8'h00, senseByte;
  logic [3:0]  unrecovFlags = 4'h0;
  logic [2:0]  exceptCat = 3'h0, senseSel;
  logic [15:0] scbPtr = 16'h0000, expPtr;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int          fail_count = 0, n_compared = 0;
  logic [7:0]  extMask [1:7] = '{8'hCE, 8'h9E, 8'hFE, 8'hFE, 8'hD2,
                                 8'h76, 8'h0E};
  las_top DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .unrecovReq(unrecovReq), .unrecovFlags(unrecovFlags),
    .exceptReq(exceptReq), .exceptCat(exceptCat),
    .exceptDetail(exceptDetail), .returnReq(returnReq), .scbPtr(scbPtr),
    .senseByte(senseByte), .senseSel(senseSel), .rptReady(rptReady),
    .complDone(complDone), .adapterHalted(halted), .adapterStop(stop));
  las_core_model uModel (.senseSel(senseSel), .senseByte(senseByte));
  ////////////////////////////////////////////////////////////////////////
  // clock, and a latch for the one-cycle stop pulse
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (stop === 1'b1) stopSeen <= 1'b1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic cycle; no latency assumed, the bound only catches a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    if (n >= 20) fail_count++;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic report(input logic u, input logic e);
    @(posedge core_clk);
    unrecovReq <= u; exceptReq <= e;
    @(posedge core_clk);
    unrecovReq <= 1'b0; exceptReq <= 1'b0;
  endtask
  task automatic waitDone;
    int n;
    n = 0;
    while (complDone !== 1'b1 && n < 30) begin
      @(posedge core_clk);
      n++;
    end
    chk({31'h0, complDone}, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values, unmapped read, write to a read-only place
  task automatic t_reset;
    rdchk(las_pkg::OFS_COMPL, 32'h0);
    rdchk(las_pkg::OFS_SUMMARY, 32'h0);
    rdchk(las_pkg::OFS_CTRL, 32'h8);
    rdchk(8'h80, 32'h0);
    wb(1'b1, las_pkg::OFS_COMPL, 32'hFF);
    rdchk(las_pkg::OFS_COMPL, 32'h0);
  endtask
  // every category, all detail bits set, a refused report while busy
  task automatic t_except;
    expPtr = 16'h0000;
    for (int c = 1; c < 8; c++) begin
      exceptCat <= 3'(c); exceptDetail <= 8'hFF; returnReq <= c[0];
      scbPtr <= 16'h1111 * 16'(c);
      if (c >= 3 && c <= 6) expPtr = 16'h1111 * 16'(c);
      report(1'b0, 1'b1);
      report(1'b1, 1'b0);
      waitDone();
      rdchk(las_pkg::OFS_COMPL, 32'h02);
      rdchk(las_pkg::OFS_SUMMARY, 32'((8'h01 << c) | c[0]));
      rdchk(las_pkg::OFS_EXT, 32'(extMask[c] | c[0]));
      rdchk(las_pkg::OFS_PTR_HI, 32'(expPtr[15:8]));
      rdchk(las_pkg::OFS_PTR_LO, 32'(expPtr[7:0]));
      rdchk(las_pkg::OFS_CTRL, 32'h1);
      wb(1'b1, las_pkg::OFS_CTRL, 32'h1);
      rdchk(las_pkg::OFS_CTRL, 32'h8);
    end
  endtask
  // unrecoverable beats a same-cycle exception, then sense and reset
  task automatic t_unrecov;
    unrecovFlags <= 4'hD; exceptCat <= 3'h3;
    report(1'b1, 1'b1);
    waitDone();
    chk({31'h0, halted}, 32'h1);
    rdchk(las_pkg::OFS_COMPL, 32'h0C);
    rdchk(las_pkg::OFS_SUMMARY, 32'hC4);
    rdchk(las_pkg::OFS_CTRL, 32'h7);
    for (int k = 0; k < 8; k++) begin
      rdchk(8'h20 + 8'(4 * k), 32'(8'h5A ^ 8'(k)));
    end
    wb(1'b1, las_pkg::OFS_CTRL, 32'h2);
    // the latch takes the pulse at the ack edge; let it settle first
    @(posedge core_clk);
    chk({31'h0, stopSeen}, 32'h1);
    rdchk(las_pkg::OFS_CTRL, 32'hC);
    rdchk(las_pkg::OFS_COMPL, 32'h0);
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_except();
    t_unrecov();
    end_of_test();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end
endmodule // link_adapter_error_status_bench
